//--- rtl/cbw_params.svh
`ifndef CBW_PARAMS_SVH
`define CBW_PARAMS_SVH

// ----------------------------------------
// Data path and patterns
// ----------------------------------------
`define CBW_DATA_W 32
`define CBW_PAT_MARK 8'hBB
`define CBW_PAT_X8 8'h11
`define CBW_PAT_X16 8'h22
`define CBW_PAT_X32 8'h44
`define CBW_SYNC_WORD 32'hAA99_5566

// ----------------------------------------
// Mode pin codes
// ----------------------------------------
`define CBW_MODE_MASTER_SERIAL 3'h0
`define CBW_MODE_SPI 3'h1
`define CBW_MODE_PAR_UP 3'h2
`define CBW_MODE_PAR_DOWN 3'h3
`define CBW_MODE_MASTER_PAR 3'h4
`define CBW_MODE_SCAN 3'h5
`define CBW_MODE_SLAVE_PAR 3'h6
`define CBW_MODE_SLAVE_SERIAL 3'h7

// ----------------------------------------
// Bits gathered per transfer and reset values
// ----------------------------------------
`define CBW_STEP_SERIAL 6'h01
`define CBW_STEP_X8 6'h08
`define CBW_STEP_X16 6'h10
`define CBW_STEP_X32 6'h20
`define CBW_FILL_RST 6'h00
`define CBW_WORD_RST 32'h0000_0000
`define CBW_MODE_RST 3'h0

`endif

//--- rtl/cbw_pkg.sv
`default_nettype none
package cbw_pkg;
	typedef enum logic [1:0] {
		CBW_WIDTH_SERIAL,
		CBW_WIDTH_X8,
		CBW_WIDTH_X16,
		CBW_WIDTH_X32
	} cbw_width_t;

	typedef enum logic [1:0] {
		CBW_HUNT_MARK,
		CBW_HUNT_CODE,
		CBW_LOCKED
	} cbw_wstate_t;
endpackage : cbw_pkg
`default_nettype wire

//--- rtl/cbw_width_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cbw_width_if;
	logic strobe;
	logic [7:0] lane;
	logic enable;
	logic clear;
	cbw_pkg::cbw_width_t width;
	logic locked;

	modport ctrl (output strobe, output lane, output enable, output clear,
		input width, input locked);
	modport det (input strobe, input lane, input enable, input clear,
		output width, output locked);
endinterface : cbw_width_if
`default_nettype wire

//--- rtl/cbw_lane_swap.sv
`timescale 1ns/1ps
`default_nettype none
module cbw_lane_swap (
	input wire logic [31:0] pins,
	output logic [31:0] stream
);
	// Each byte lane carries its most significant bit on the lowest pin.
	for (genvar b = 0; b < 4; b++) begin : g_lane
		for (genvar i = 0; i < 8; i++) begin : g_bit
			assign stream[8 * b + i] = pins[8 * b + 7 - i];
		end
	end
endmodule : cbw_lane_swap
`default_nettype wire

//--- rtl/cbw_width_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbw_params.svh"
module cbw_width_detect (
	input wire logic mclk,
	input wire logic resetn,
	cbw_width_if.det wif
);
	import cbw_pkg::*;

	cbw_wstate_t state, next_state;
	cbw_width_t width, next_width;
	logic locked, next_locked;
	logic take;

	assign take = wif.enable && wif.strobe && !wif.clear;

	always_comb begin
		next_state = state;
		next_width = width;
		if (wif.clear) begin
			next_state = CBW_HUNT_MARK;
			next_width = CBW_WIDTH_X8;
		end else if (take) begin
			case (state)
				CBW_HUNT_MARK: begin
					if (wif.lane == `CBW_PAT_MARK) begin
						next_state = CBW_HUNT_CODE;
					end
				end
				CBW_HUNT_CODE: begin
					if (wif.lane == `CBW_PAT_X8) begin
						next_width = CBW_WIDTH_X8;
						next_state = CBW_LOCKED;
					end else if (wif.lane == `CBW_PAT_X16) begin
						next_width = CBW_WIDTH_X16;
						next_state = CBW_LOCKED;
					end else if (wif.lane == `CBW_PAT_X32) begin
						next_width = CBW_WIDTH_X32;
						next_state = CBW_LOCKED;
					end else begin
						next_state = CBW_HUNT_MARK;
					end
				end
				CBW_LOCKED: next_state = CBW_LOCKED;
				default: next_state = CBW_HUNT_MARK;
			endcase
		end
		next_locked = (next_state == CBW_LOCKED);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= CBW_HUNT_MARK;
			width <= CBW_WIDTH_X8;
			locked <= 1'h0;
		end else begin
			state <= next_state;
			width <= next_width;
			locked <= next_locked;
		end
	end

	assign wif.width = width;
	// The lock flag has a flop of its own so the top output comes straight from a register.
	assign wif.locked = locked;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	code_x16_a: assert property (@(posedge mclk) disable iff (!resetn)
		(take && state == CBW_HUNT_CODE && wif.lane == `CBW_PAT_X16)
		|=> (wif.locked && width == CBW_WIDTH_X16))
		else $error("x16 code did not lock the width");
	bad_code_a: assert property (@(posedge mclk) disable iff (!resetn)
		(take && state == CBW_HUNT_CODE && wif.lane != `CBW_PAT_X8
		&& wif.lane != `CBW_PAT_X16 && wif.lane != `CBW_PAT_X32)
		|=> (state == CBW_HUNT_MARK))
		else $error("bad width code did not restart the search");
	lock_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		(wif.locked && !wif.clear) |=> (wif.locked && $stable(width)))
		else $error("locked width changed without a restart");
endmodule : cbw_width_detect
`default_nettype wire

//--- rtl/cbw_sync_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbw_params.svh"
module cbw_sync_detect (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic config_clock,
	input wire logic [31:0] cfg_data,
	input wire logic port_select_n,
	input wire logic [2:0] mode_pins,
	input wire logic restart_pin_n,
	input wire logic scan_restart_instruction,
	input wire logic internal_restart_command,
	output cbw_pkg::cbw_width_t bus_width,
	output logic width_locked,
	output logic parallel_mode,
	output logic sync_found,
	output logic [31:0] word_data,
	output logic word_valid
);
	import cbw_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// The data pins are synchronised alongside the clock pin so that both
	// arrive with the same latency; the source holds data around its edge.
	logic clk_s1, clk_s2, clk_prev;
	logic sel_s1, sel_s2;
	logic rst_s1, rst_s2;
	logic [2:0] mode_s1, mode_s2;
	logic [31:0] data_s1, data_s2;
	// The mode is taken only once the chain holds real pin values, so the
	// reset value of the synchroniser is never latched as a mode.
	logic ready_s1, ready_s2;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clk_s1 <= 1'h0;
			clk_s2 <= 1'h0;
			clk_prev <= 1'h0;
			sel_s1 <= 1'h1;
			sel_s2 <= 1'h1;
			rst_s1 <= 1'h1;
			rst_s2 <= 1'h1;
			mode_s1 <= `CBW_MODE_RST;
			mode_s2 <= `CBW_MODE_RST;
			data_s1 <= `CBW_WORD_RST;
			data_s2 <= `CBW_WORD_RST;
			ready_s1 <= 1'h0;
			ready_s2 <= 1'h0;
		end else begin
			clk_s1 <= config_clock;
			clk_s2 <= clk_s1;
			clk_prev <= clk_s2;
			sel_s1 <= port_select_n;
			sel_s2 <= sel_s1;
			rst_s1 <= restart_pin_n;
			rst_s2 <= rst_s1;
			mode_s1 <= mode_pins;
			mode_s2 <= mode_s1;
			data_s1 <= cfg_data;
			data_s2 <= data_s1;
			ready_s1 <= 1'h1;
			ready_s2 <= ready_s1;
		end
	end

	// ----------------------------------------
	// Restart, mode and sample strobe
	// ----------------------------------------
	logic clear;
	logic clk_rise;
	logic mode_valid, next_mode_valid;
	logic [2:0] mode_reg, next_mode_reg;
	logic next_parallel;
	logic strobe;
	logic hunt_strobe;
	logic [31:0] stream;

	// A low restart pin holds the width lock, sync search and word fill cleared for as long as it stays low; word_data keeps its last word.
	assign clear = !rst_s2 || scan_restart_instruction || internal_restart_command;
	assign clk_rise = clk_s2 && !clk_prev;

	always_comb begin
		next_mode_reg = mode_reg;
		next_mode_valid = mode_valid;
		if (ready_s2 && (clear || !mode_valid)) begin
			next_mode_reg = mode_s2;
			next_mode_valid = 1'h1;
		end
		case (next_mode_reg)
			`CBW_MODE_PAR_UP, `CBW_MODE_PAR_DOWN,
			`CBW_MODE_MASTER_PAR, `CBW_MODE_SLAVE_PAR: next_parallel = 1'h1;
			default: next_parallel = 1'h0;
		endcase
	end

	// The serial modes have no chip select, so only parallel modes gate on it.
	assign strobe = clk_rise && mode_valid && !clear
		&& (!parallel_mode || !sel_s2);
	assign hunt_strobe = strobe && (!parallel_mode || width_locked);

	cbw_lane_swap u_swap (
		.pins(data_s2),
		.stream(stream)
	);

	// ----------------------------------------
	// Width detection
	// ----------------------------------------
	cbw_width_if wif ();

	assign wif.strobe = strobe;
	assign wif.lane = stream[7:0];
	assign wif.enable = parallel_mode;
	assign wif.clear = clear;

	cbw_width_detect u_width (
		.mclk(mclk),
		.resetn(resetn),
		.wif(wif)
	);

	assign width_locked = wif.locked;

	// ----------------------------------------
	// Sync hunt and word packing
	// ----------------------------------------
	cbw_width_t eff_width;
	cbw_width_t next_bus_width;
	logic [31:0] shift, next_shift;
	logic [31:0] shifted;
	logic [5:0] fill, next_fill;
	logic [5:0] step;
	logic [5:0] fill_sum;
	logic next_sync;
	logic [31:0] next_word;
	logic next_valid;

	always_comb begin
		eff_width = parallel_mode ? wif.width : CBW_WIDTH_SERIAL;
		next_bus_width = next_parallel ? wif.width : CBW_WIDTH_SERIAL;
		case (eff_width)
			CBW_WIDTH_SERIAL: begin
				shifted = {shift[30:0], data_s2[0]};
				step = `CBW_STEP_SERIAL;
			end
			CBW_WIDTH_X8: begin
				shifted = {shift[23:0], stream[7:0]};
				step = `CBW_STEP_X8;
			end
			CBW_WIDTH_X16: begin
				shifted = {shift[15:0], stream[15:0]};
				step = `CBW_STEP_X16;
			end
			default: begin
				shifted = stream;
				step = `CBW_STEP_X32;
			end
		endcase
		fill_sum = fill + step;
		next_shift = shift;
		next_fill = fill;
		next_sync = sync_found;
		next_word = word_data;
		next_valid = 1'h0;
		// A restart wins over a sync match in the same cycle and drops any partial word.
		if (clear) begin
			next_shift = `CBW_WORD_RST;
			next_fill = `CBW_FILL_RST;
			next_sync = 1'h0;
		end else if (hunt_strobe) begin
			next_shift = shifted;
			if (!sync_found) begin
				// Nothing leaves the block before the alignment word.
				if (shifted == `CBW_SYNC_WORD) begin
					next_sync = 1'h1;
					next_fill = `CBW_FILL_RST;
				end
			end else if (fill_sum == `CBW_STEP_X32) begin
				next_word = shifted;
				next_valid = 1'h1;
				next_fill = `CBW_FILL_RST;
			end else begin
				next_fill = fill_sum;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= `CBW_MODE_RST;
			mode_valid <= 1'h0;
			parallel_mode <= 1'h0;
			bus_width <= CBW_WIDTH_X8;
			shift <= `CBW_WORD_RST;
			fill <= `CBW_FILL_RST;
			sync_found <= 1'h0;
			word_data <= `CBW_WORD_RST;
			word_valid <= 1'h0;
		end else begin
			mode_reg <= next_mode_reg;
			mode_valid <= next_mode_valid;
			parallel_mode <= next_parallel;
			bus_width <= next_bus_width;
			shift <= next_shift;
			fill <= next_fill;
			sync_found <= next_sync;
			word_data <= next_word;
			word_valid <= next_valid;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	serial_ignore_a: assert property (
		(mode_valid && !parallel_mode) |-> !width_locked)
		else $error("width locked outside a parallel mode");
	sync_after_lock_a: assert property (
		$rose(sync_found) |-> (!$past(parallel_mode) || $past(width_locked)))
		else $error("sync found before width lock in parallel mode");
	sync_match_a: assert property (
		(hunt_strobe && !sync_found && shifted == `CBW_SYNC_WORD) |=> sync_found)
		else $error("sync word seen but not taken");
	no_early_word_a: assert property (
		!sync_found |-> !word_valid)
		else $error("word emitted before sync");
	word_x32_a: assert property (
		(hunt_strobe && sync_found && eff_width == CBW_WIDTH_X32)
		|=> (word_valid && word_data == $past(stream)))
		else $error("32-bit transfer not passed on as one word");
	word_spacing_a: assert property (
		word_valid |=> !word_valid)
		else $error("words emitted back to back");
	restart_clear_a: assert property (
		clear |=> (!sync_found && !width_locked && !word_valid))
		else $error("restart did not clear width and sync");
	width_follow_a: assert property (
		(parallel_mode && width_locked && !clear) |=> (bus_width == $past(wif.width)))
		else $error("bus width output does not follow locked width");
	x8_pack_a: assert property (
		(hunt_strobe && sync_found && eff_width == CBW_WIDTH_X8 && fill == 6'h18)
		|=> (word_valid && word_data[7:0] == $past(stream[7:0])))
		else $error("fourth byte did not close the word");
	x16_pack_a: assert property (
		(hunt_strobe && sync_found && eff_width == CBW_WIDTH_X16 && fill == 6'h10)
		|=> (word_valid && word_data[15:0] == $past(stream[15:0])))
		else $error("second halfword did not close the word");
	serial_pack_a: assert property (
		(hunt_strobe && sync_found && eff_width == CBW_WIDTH_SERIAL && fill == 6'h1f)
		|=> (word_valid && word_data[0] == $past(data_s2[0])))
		else $error("last serial bit did not close the word");

	// ----------------------------------------
	// Hold, range and restart checks
	// ----------------------------------------
	hunt_gate_a: assert property (
		(parallel_mode && !width_locked && !clear) |=> (shift == $past(shift)))
		else $error("sync hunt shifted data before width lock");
	serial_width_a: assert property (
		(mode_valid && !parallel_mode && !clear) |=> (bus_width == CBW_WIDTH_SERIAL))
		else $error("serial mode shows a parallel bus width");
	mode_hold_a: assert property (
		(mode_valid && !clear) |=> $stable(parallel_mode))
		else $error("mode class changed without a restart");
	sync_hold_a: assert property (
		(sync_found && !clear) |=> sync_found)
		else $error("sync lost without a restart");
	word_hold_a: assert property (
		!word_valid |-> $stable(word_data))
		else $error("word data changed without a word strobe");
	fill_range_a: assert property (
		fill < `CBW_STEP_X32)
		else $error("word fill count passed a full word");
	restart_width_a: assert property (
		clear |=> (wif.width == CBW_WIDTH_X8))
		else $error("restart did not return the detector to idle width");
endmodule : cbw_sync_detect
`default_nettype wire

//--- tb/cbw_src.sv
`timescale 1ns/1ps
`default_nettype none
module cbw_src (
	input wire logic mclk,
	output logic config_clock,
	output logic [31:0] cfg_data
);
	initial begin
		config_clock = 1'b0;
		cfg_data = 32'hFFFF_FFFF;
	end

	function automatic logic [31:0] lane_rev(input logic [31:0] w);
		for (int i = 0; i < 32; i++) lane_rev[i] = w[(i & 24) + 7 - (i & 7)];
	endfunction : lane_rev

	// The clock stands low between transfers; stale data is inverted so it cannot pass.
	task automatic xfer(input logic [31:0] d);
		@(posedge mclk) #2;
		cfg_data = d;
		@(posedge mclk) #2;
		config_clock = 1'b1;
		repeat (3) @(posedge mclk);
		#2;
		config_clock = 1'b0;
		repeat (2) @(posedge mclk);
		#2;
		cfg_data = ~d;
	endtask : xfer

	task automatic send(input logic [31:0] w, input int nb, input logic [31:0] fill);
		for (int i = 0; i < 4 / nb; i++) begin
			case (nb)
				1: xfer({fill[31:8], w[31 - 8 * i -: 8]});
				2: xfer({fill[31:16], w[31 - 16 * i -: 16]});
				default: xfer(w);
			endcase
		end
	endtask : send

	task automatic send_bits(input logic [31:0] w, input logic [31:0] fill);
		for (int i = 31; i >= 0; i--) xfer({fill[31:1], w[i]});
	endtask : send_bits

	task automatic header(input int nb, input logic [31:0] fill);
		logic [31:0] hdr [6];
		hdr = '{32'hFFFF_FFFF, 32'h0000_00DD, 32'h8844_0022,
			32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h5599_AA66};
		for (int i = 0; i < 6; i++) begin
			if (nb == 0) send_bits(lane_rev(hdr[i]), fill);
			else send(hdr[i], nb, fill);
		end
	endtask : header
endmodule : cbw_src
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cbw_pkg::*;
	logic mclk, resetn, config_clock, port_select_n, restart_pin_n;
	logic scan_restart_instruction, internal_restart_command;
	logic [31:0] cfg_data, word_data, w;
	logic [2:0] mode_pins;
	cbw_width_t bus_width;
	logic width_locked, parallel_mode, sync_found, word_valid;
	int err_count = 0;
	int checks = 0;
	int seed = 92437;
	logic [31:0] expq [$];

	cbw_src u_src (.mclk(mclk), .config_clock(config_clock), .cfg_data(cfg_data));
	cbw_sync_detect u_dut (.mclk(mclk), .resetn(resetn), .config_clock(config_clock),
		.cfg_data(cfg_data), .port_select_n(port_select_n), .mode_pins(mode_pins),
		.restart_pin_n(restart_pin_n), .scan_restart_instruction(scan_restart_instruction),
		.internal_restart_command(internal_restart_command), .bus_width(bus_width),
		.width_locked(width_locked), .parallel_mode(parallel_mode),
		.sync_found(sync_found), .word_data(word_data), .word_valid(word_valid));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic chk_flag(input logic got, input logic exp, input string msg);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : chk_flag

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk_word

	task automatic complete_run;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run

	always @(negedge mclk) begin
		if (word_valid === 1'b1) begin
			if (expq.size() == 0) chk_flag(1'b1, 1'b0, "word before sync");
			else chk_word(word_data, expq.pop_front(), "word");
		end
	end

	// ----------------------------------------
	// Restart kinds: 0 pin, 1 scan instruction, 2 internal command
	// ----------------------------------------
	task automatic restart(input int kind);
		@(posedge mclk) #2;
		restart_pin_n = (kind != 0);
		scan_restart_instruction = (kind == 1);
		internal_restart_command = (kind == 2);
		repeat (4) @(posedge mclk);
		#2;
		restart_pin_n = 1'b1;
		scan_restart_instruction = 1'b0;
		internal_restart_command = 1'b0;
		repeat (2) @(posedge mclk);
		#2;
		chk_flag(width_locked, 1'b0, "lock kept");
		chk_flag(sync_found, 1'b0, "sync kept");
	endtask : restart

	// A bytes-per-transfer of zero means a serial stream.
	task automatic stream(input logic [2:0] mode, input int nb, input int kind);
		mode_pins = mode;
		restart(kind);
		if (nb == 4) begin
			port_select_n = 1'b1;
			u_src.send(32'h0000_00DD, 4, $random(seed));
			u_src.send(32'h0000_0022, 4, $random(seed));
			repeat (4) @(posedge mclk);
			#2;
			chk_flag(width_locked, 1'b0, "deselected code locked");
			port_select_n = 1'b0;
			u_src.send(32'h0000_00DD, 4, $random(seed));
			u_src.send(32'h0000_0011, 4, $random(seed));
			repeat (4) @(posedge mclk);
			#2;
			chk_flag(width_locked, 1'b0, "bad code locked");
		end
		u_src.header(nb, $random(seed));
		repeat (4) @(posedge mclk);
		#2;
		chk_flag(sync_found, 1'b1, "sync missed");
		chk_flag(width_locked, nb != 0, "lock");
		chk_word(32'(bus_width), (nb == 4) ? 3 : nb, "width");
		for (int i = 0; i < 4; i++) begin
			w = (i == 0) ? 32'h0000_00BB : (i == 1) ? 32'h0000_0011 : $random(seed);
			expq.push_back(w);
			if (nb == 0) u_src.send_bits(w, $random(seed));
			else u_src.send(u_src.lane_rev(w), nb, $random(seed));
		end
		repeat (8) @(posedge mclk);
		#2;
		chk_word(32'(bus_width), (nb == 4) ? 3 : nb, "width moved");
		chk_word(expq.size(), 0, "words lost");
	endtask : stream

	initial begin
		resetn = 1'b0;
		port_select_n = 1'b0;
		restart_pin_n = 1'b1;
		scan_restart_instruction = 1'b0;
		internal_restart_command = 1'b0;
		mode_pins = 3'h6;
		repeat (4) @(posedge mclk);
		#2;
		chk_word(32'(bus_width), 1, "reset width");
		resetn = 1'b1;
		repeat (4) @(posedge mclk);
		#2;
		chk_flag(parallel_mode, 1'b1, "power-up mode");
		for (int m = 0; m < 8; m++) begin
			mode_pins = m[2:0];
			restart(m % 3);
			chk_flag(parallel_mode, m inside {2, 3, 4, 6}, "mode class");
		end
		stream(3'h6, 4, 0);
		stream(3'h2, 2, 1);
		stream(3'h4, 1, 2);
		stream(3'h7, 0, 1);
		complete_run();
	end

	initial begin
		#3_000_000;
		err_count++;
		$display("MISMATCH %0t watchdog", $time);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
